/* File: shared/trng_pkg.sv */
// Shared constants and types for the health-gated random generator
package trng_pkg;
    // ===================================
    // Octet and test geometry
    localparam int OCTET_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int STUCK_LIMIT = 32;
    localparam int WIN_LEN = 256;
    localparam int ONES_MIN = 96;
    localparam int ONES_MAX = 160;
    localparam int RUN_LIMIT = 24;
    localparam int SELFTEST_LEN = 64;
    // ===================================
    // Periodic test spacing
    localparam real PERIOD_US = 1000.0;
    localparam real CLK_MHZ = 25.0;
    localparam int PERIOD_CYCLES = int'(PERIOD_US * CLK_MHZ);
    // ===================================
    // Scheduling modes and generator states
    localparam logic SCHED_PERIODIC = 1'b0;
    localparam logic SCHED_CONTINUOUS = 1'b1;
    typedef enum logic [1:0] {
        st_idle,
        st_powerup,
        st_run,
        st_dead
    } gen_state_e;
endpackage

/* File: shared/octet_if.sv */
// Octet stream carrier between generator core and its buffer
`timescale 1ns/1ps
interface octet_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: rtl/octet_fifo.sv */
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/1ps
module octet_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic flush,
    octet_if.snk in_s,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_depth_check
        $error("octet_fifo depth must be a power of two");
    end
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire full = (wr_ptr[AW] != rd_ptr[AW])
        && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);
    wire do_wr = in_s.valid && !full;
    wire do_rd = out_ready && !empty;
    assign in_s.ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr[AW-1:0]];
    always_ff @(posedge ref_clk)
    begin
        if (ce && do_wr)
            mem[wr_ptr[AW-1:0]] <= in_s.data;
    end
    always_ff @(posedge ref_clk)
    begin
        if (rst || (ce && flush))
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else if (ce)
        begin
            wr_ptr <= wr_ptr + (AW+1)'(do_wr);
            rd_ptr <= rd_ptr + (AW+1)'(do_rd);
        end
    end
endmodule

/* File: rtl/trng_health_gated_output.sv */
// Health-test gating and octet delivery around a physical entropy source
`timescale 1ns/1ps
module trng_health_gated_output
    import trng_pkg::*;
#(
    parameter int PERIOD = trng_pkg::PERIOD_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    input wire logic raw_bit,
    input wire logic raw_valid,
    input wire logic sched_mode,
    input wire logic selftest_start,
    input wire logic rd_req,
    output logic [trng_pkg::OCTET_W-1:0] rd_data,
    output logic rd_valid,
    output logic healthy,
    output logic total_fail,
    output logic defect,
    output logic selftest_busy,
    output logic selftest_done,
    output logic selftest_pass
);
    import trng_pkg::*;
    if (PERIOD < WIN_LEN)
    begin : g_period_check
        $error("periodic spacing shorter than one test window");
    end
    // ===================================
    // State
    gen_state_e state;
    logic [5:0] same_cnt;
    logic last_bit;
    logic [8:0] win_cnt;
    logic [8:0] ones_cnt;
    logic [4:0] run_cnt;
    logic win_active;
    logic [31:0] period_cnt;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic [6:0] st_cnt;
    logic st_fail;
    logic st_saw0;
    logic st_saw1;
    octet_if #(.W(OCTET_W)) push ();
    logic fifo_valid;
    logic [OCTET_W-1:0] fifo_data;
    // ===================================
    // Decoding
    wire stuck_hit = raw_valid && (raw_bit == last_bit)
        && (same_cnt == 6'(STUCK_LIMIT - 1));
    wire run_hit = raw_valid && win_active && (raw_bit == last_bit)
        && (run_cnt == 5'(RUN_LIMIT - 1));
    wire win_end = raw_valid && win_active && (win_cnt == 9'(WIN_LEN - 1));
    wire [8:0] next_ones = ones_cnt + 9'(raw_bit);
    wire win_bad = win_end && ((next_ones < 9'(ONES_MIN))
        || (next_ones > 9'(ONES_MAX)));
    wire stat_fail = win_bad || run_hit;
    wire period_due = (period_cnt == 32'(PERIOD - 1));
    wire win_start = !win_active && ((state == st_powerup)
        || (state == st_run && (sched_mode == SCHED_CONTINUOUS
        || period_due)));
    wire pass_open = (state == st_run) && !stuck_hit;
    wire octet_done = raw_valid && (bit_cnt == 3'd7);
    wire drop = stuck_hit || stat_fail || state != st_run;
    // No read is served in the cycle a failure shows, before the flush
    wire fifo_pop = rd_req && fifo_valid && !drop;
    // ===================================
    // Health state machine
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            state <= st_idle;
        else if (ce)
        begin
            case (state)
                st_idle:
                    if (start)
                        state <= st_powerup;
                st_powerup:
                    if (stuck_hit || stat_fail)
                        state <= st_dead;
                    else if (win_end)
                        state <= st_run;
                st_run:
                    if (stuck_hit || stat_fail)
                        state <= st_dead;
                default:
                    state <= st_dead;
            endcase
        end
    end
    // ===================================
    // Total failure and online statistics
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            same_cnt <= '0;
            last_bit <= 1'b0;
            run_cnt <= '0;
        end
        else if (ce && raw_valid)
        begin
            last_bit <= raw_bit;
            same_cnt <= (raw_bit == last_bit) ? same_cnt + 6'd1 : 6'd0;
            run_cnt <= (raw_bit == last_bit) ? run_cnt + 5'd1 : 5'd0;
        end
    end
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            win_active <= 1'b0;
            win_cnt <= '0;
            ones_cnt <= '0;
            period_cnt <= '0;
        end
        else if (ce)
        begin
            if (win_start)
                win_active <= 1'b1;
            else if (win_end)
                win_active <= 1'b0;
            if (win_active && raw_valid)
            begin
                win_cnt <= win_end ? 9'd0 : win_cnt + 9'd1;
                ones_cnt <= win_end ? 9'd0 : next_ones;
            end
            // Periodic spacing counts from the end of each window
            if (state != st_run || win_active || period_due)
                period_cnt <= '0;
            else
                period_cnt <= period_cnt + 32'd1;
        end
    end
    // ===================================
    // Octet assembly; raw bits pass unwhitened
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            shift <= '0;
            bit_cnt <= '0;
        end
        else if (ce && raw_valid)
        begin
            shift <= {shift[6:0], raw_bit};
            bit_cnt <= bit_cnt + 3'd1;
        end
    end
    // An octet with a failing bit in it is never pushed
    assign push.valid = ce && octet_done && pass_open && !drop;
    assign push.data = {shift[6:0], raw_bit};
    // Flushing on failure costs buffered data but keeps it unreachable
    octet_fifo #(.W(OCTET_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .flush(state == st_dead),
        .in_s(push),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(fifo_pop)
    );
    // ===================================
    // Software self-test
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            selftest_busy <= 1'b0;
            selftest_done <= 1'b0;
            selftest_pass <= 1'b0;
            st_cnt <= '0;
            st_fail <= 1'b0;
            st_saw0 <= 1'b0;
            st_saw1 <= 1'b0;
        end
        else if (ce)
        begin
            if (selftest_start && !selftest_busy)
            begin
                selftest_busy <= 1'b1;
                selftest_done <= 1'b0;
                // A stale pass would be read as the new run's result
                selftest_pass <= 1'b0;
                st_cnt <= '0;
                st_fail <= 1'b0;
                st_saw0 <= 1'b0;
                st_saw1 <= 1'b0;
            end
            else if (selftest_busy && raw_valid)
            begin
                st_cnt <= st_cnt + 7'd1;
                st_saw0 <= st_saw0 | !raw_bit;
                st_saw1 <= st_saw1 | raw_bit;
                st_fail <= st_fail | stuck_hit;
                if (st_cnt == 7'(SELFTEST_LEN - 1))
                begin
                    selftest_busy <= 1'b0;
                    selftest_done <= 1'b1;
                    selftest_pass <= !st_fail && !stuck_hit
                        && (st_saw0 | !raw_bit)
                        && (st_saw1 | raw_bit);
                end
            end
        end
    end
    // ===================================
    // Read port and status
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rd_data <= '0;
            rd_valid <= 1'b0;
            healthy <= 1'b0;
            total_fail <= 1'b0;
            defect <= 1'b0;
        end
        else if (ce)
        begin
            rd_valid <= fifo_pop;
            rd_data <= fifo_pop ? fifo_data : '0;
            healthy <= (state == st_run) && !drop;
            if (stuck_hit && state != st_idle)
                total_fail <= 1'b1;
            if (stat_fail && state != st_idle)
                defect <= 1'b1;
        end
    end
endmodule

/* File: sim/trng_health_gated_output_assertions.sv */
// Port-level checker for the health-gated random generator
`timescale 1ns/1ps
module trng_health_gated_output_assertions
    import trng_pkg::*;
#(
    parameter int PERIOD = trng_pkg::PERIOD_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic start,
    input wire logic raw_bit,
    input wire logic raw_valid,
    input wire logic sched_mode,
    input wire logic selftest_start,
    input wire logic rd_req,
    input wire logic [trng_pkg::OCTET_W-1:0] rd_data,
    input wire logic rd_valid,
    input wire logic healthy,
    input wire logic total_fail,
    input wire logic defect,
    input wire logic selftest_busy,
    input wire logic selftest_done,
    input wire logic selftest_pass
);
    // ===================================
    // Properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence st_launch;
        selftest_start && !selftest_busy && ce;
    endsequence
    a_valid_after_req: assert property (rd_valid |-> $past(rd_req))
        else $error("read answer without request");
    a_valid_when_ok: assert property (rd_valid |-> $past(healthy))
        else $error("octet given while unhealthy");
    a_fail_blocks: assert property ($past(total_fail) |-> !rd_valid)
        else $error("octet given after total failure");
    a_defect_blocks: assert property ($past(defect) |-> !rd_valid)
        else $error("octet given after defect");
    a_fail_sticky: assert property (total_fail |=> total_fail)
        else $error("total failure flag dropped");
    a_defect_sticky: assert property (defect |=> defect)
        else $error("defect flag dropped");
    a_idle_data_zero: assert property (
        !rd_valid |-> rd_data == 8'h00)
        else $error("stale data shown");
    a_healthy_clean: assert property (
        healthy |-> !total_fail && !defect)
        else $error("healthy with a failure flag");
    a_selftest_go: assert property (
        st_launch |=> selftest_busy && !selftest_done)
        else $error("self-test did not start");
    a_pass_done: assert property (
        selftest_pass |-> selftest_done && !selftest_busy)
        else $error("pass flag without finished test");
endmodule

bind trng_health_gated_output
    trng_health_gated_output_assertions #(.PERIOD(PERIOD)) chk_u (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .start(start), .raw_bit(raw_bit),
    .raw_valid(raw_valid), .sched_mode(sched_mode),
    .selftest_start(selftest_start), .rd_req(rd_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .healthy(healthy), .total_fail(total_fail),
    .defect(defect), .selftest_busy(selftest_busy),
    .selftest_done(selftest_done), .selftest_pass(selftest_pass));

/* File: sim/tb_trng_health_gated_output.sv */
// Self-checking testbench for the health-gated random generator
`timescale 1ns/1ps
module tb_trng_health_gated_output;
    import trng_pkg::*;
    logic ref_clk = 0, rst = 1, start = 0, raw_bit = 0, raw_valid = 0;
    logic ce = 1;
    logic sched_mode = SCHED_PERIODIC, selftest_start = 0, rd_req = 0;
    logic [7:0] rd_data;
    logic rd_valid, healthy, total_fail, defect, st_busy, st_done, st_pass;
    int miscompares = 0, n_compared = 0;
    // ===================================
    // Short period keeps the run brief; must stay at least one window long
    trng_health_gated_output #(.PERIOD(300)) dut_u (.ref_clk(ref_clk),
        .rst(rst), .ce(ce), .start(start), .raw_bit(raw_bit),
        .raw_valid(raw_valid), .sched_mode(sched_mode),
        .selftest_start(selftest_start), .rd_req(rd_req), .rd_data(rd_data),
        .rd_valid(rd_valid), .healthy(healthy), .total_fail(total_fail),
        .defect(defect), .selftest_busy(st_busy), .selftest_done(st_done),
        .selftest_pass(st_pass));
    initial forever #20 ref_clk = ~ref_clk;
    // ===================================
    // Helpers
    task check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        if (miscompares == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic pulse(ref logic s);
        @(negedge ref_clk) s = 1;
        @(negedge ref_clk) s = 0;
    endtask
    task do_reset;
        @(negedge ref_clk) rst = 1;
        repeat (16) @(negedge ref_clk);
        rst = 0;
        check({healthy, total_fail, defect}, 0);
        check({st_busy, st_done, st_pass}, 0);
        check({rd_valid, rd_data}, 0);
    endtask
    // Octets go out MSB first, one strobe every other cycle
    task feed(input logic [7:0] v, input int n);
        for (int k = 0; k < n * 8; k++)
        begin
            @(negedge ref_clk) raw_bit = v[7 - k % 8];
            raw_valid = 1;
            @(negedge ref_clk) raw_valid = 0;
        end
        repeat (4) @(negedge ref_clk);
    endtask
    task rd_none;
        pulse(rd_req);
        check({rd_valid, rd_data}, 0);
    endtask
    // ===================================
    // Scenarios
    task t_powerup_and_drain;
        do_reset();
        pulse(start);
        rd_none();
        feed(8'h5a, 31);
        check(healthy, 0);
        feed(8'h5a, 1);
        check(healthy, 1);
        feed(8'h5a, 20);
        @(negedge ref_clk) rd_req = 1;
        for (int i = 0; i < 17; i++)
        begin
            @(negedge ref_clk);
            check({rd_valid, rd_data}, i < 16 ? 9'h15a : 9'h0);
        end
        rd_req = 0;
    endtask
    task t_defect_continuous;
        sched_mode = SCHED_CONTINUOUS;
        feed(8'hfe, 64);
        check({defect, healthy}, 2'b10);
        rd_none();
    endtask
    task t_dead_at_start;
        do_reset();
        sched_mode = SCHED_PERIODIC;
        pulse(start);
        feed(8'h00, 5);
        check(total_fail, 1);
        feed(8'h5a, 40);
        check(healthy, 0);
        rd_none();
    endtask
    task t_fail_in_run;
        do_reset();
        pulse(start);
        feed(8'h5a, 36);
        feed(8'h00, 5);
        check({total_fail, healthy}, 2'b10);
        rd_none();
    endtask
    // Periodic mode leaves a gap with no window; continuous closes it
    task t_schedule;
        do_reset();
        sched_mode = SCHED_PERIODIC;
        pulse(start);
        feed(8'h5a, 32);
        feed(8'hff, 3);
        feed(8'hf0, 1);
        check({defect, healthy}, 2'b01);
        sched_mode = SCHED_CONTINUOUS;
        feed(8'hff, 3);
        feed(8'hf0, 1);
        check({defect, healthy}, 2'b10);
    endtask
    task t_selftest;
        do_reset();
        pulse(selftest_start);
        check({st_busy, st_done}, 2'b10);
        // Frozen clock enable must not let bits count
        ce = 0;
        feed(8'h5a, 8);
        ce = 1;
        check({st_busy, st_done}, 2'b10);
        feed(8'h5a, 8);
        check({st_busy, st_done, st_pass}, 3'b011);
        pulse(selftest_start);
        feed(8'h00, 8);
        check({st_busy, st_done, st_pass}, 3'b010);
    endtask
    // ===================================
    // Sequence and watchdog
    initial
    begin
        t_powerup_and_drain();
        t_defect_continuous();
        t_dead_at_start();
        t_fail_in_run();
        t_schedule();
        t_selftest();
        report_and_stop();
    end
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        miscompares++;
        report_and_stop();
    end
endmodule
